// file: rqh_checker.sv
module rqh_checker (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [rqh_pkg::NREF-1:0][3:0] ext_flags,
	input wire logic switch_evt,
	input wire logic exit_evt,
	input wire logic signed [rqh_pkg::PH_W-1:0] phase_err,
	input wire logic signed [rqh_pkg::PH_W-1:0] loop_phase_err,
	input wire logic [rqh_pkg::NREF-1:0] ref_valid,
	input wire logic [rqh_pkg::NREF-1:0] status_pins,
	input wire logic osc_valid,
	input wire logic osc_los,
	input wire logic slew_active
);
	import rqh_pkg::*;
	logic [31:0] ctrl_reg;
	logic [NREF-1:0][3:0] en_reg;
	logic [15:0] vt0_reg;
	logic [15:0] step_reg;
	logic signed [PH_W-1:0] lpe_reg;
	logic [NREF-1:0] pin_need;
	logic [NREF-1:0] en_any;
	logic slew_req;
	logic [PH_W-1:0] step_abs;

	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the writable settings, since the register file is out of sight here.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RST;
			en_reg <= '0;
			vt0_reg <= '0;
			step_reg <= SLEW_RST[15:0];
			lpe_reg <= '0;
		end else begin
			lpe_reg <= loop_phase_err;
			if (wr && addr == A_CTRL)
				ctrl_reg <= wdata;
			if (wr && addr == A_SLEW)
				step_reg <= wdata[15:0];
			if (wr && addr == A_REF_BASE)
				vt0_reg <= wdata[31:16];
			for (int r = 0; r < NREF; r++)
				if (wr && addr == A_REF_BASE + 8'(16 * r))
					en_reg[r] <= wdata[3:0];
		end
	end

	// Only the pin-visible monitors can be predicted; the frequency flag is internal.
	always_comb begin
		for (int r = 0; r < NREF; r++) begin
			pin_need[r] = |(ext_flags[r][3:1] & en_reg[r][3:1]);
			en_any[r] = |en_reg[r];
		end
	end
	assign slew_req = (switch_evt | exit_evt) & ctrl_reg[C_SLEW] & ~(ctrl_reg[C_PPS] & ctrl_reg[C_ZDS]);
	assign step_abs = (loop_phase_err >= lpe_reg) ? loop_phase_err - lpe_reg : lpe_reg - loop_phase_err;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// A slew in progress long enough that the entry jump has left the output.
	sequence s_slew_req;
		slew_req;
	endsequence
	sequence s_slewing;
		slew_active [*3] ##0 !$past(switch_evt | exit_evt, 2) ##0 $stable(phase_err)
			##0 ($past(phase_err) == $past(phase_err, 2));
	endsequence

	chk_osc_valid_mix: assert property (osc_valid == (ctrl_reg[C_BYP] | ~osc_los))
		else $error("oscillator valid does not follow bypass and loss flag");
	chk_pin_follow: assert property ((pin_need & ~status_pins) == '0)
		else $error("enabled monitor flag missing on status pins");
	chk_pin_disabled: assert property ((status_pins & ~en_any) == '0)
		else $error("status pin raised with no monitor enabled");
	chk_flag_blocks: assert property ((ref_valid & status_pins) == '0)
		else $error("reference valid while a flag is up");
	chk_valid_wait: assert property ((status_pins[0] && vt0_reg >= 16'h0002) |=> !ref_valid[0] [*8])
		else $error("reference qualified before validation time");
	chk_slew_start: assert property (s_slew_req |=> slew_active)
		else $error("slew did not start on event");
	chk_slew_cause: assert property ($rose(slew_active) |-> $past(slew_req))
		else $error("slew started without an enabled event");
	chk_slew_rate: assert property (s_slewing |-> step_abs <= PH_W'(step_reg))
		else $error("phase moved more than the step limit");
	chk_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
		else $error("read data not zero outside read cycle");
	chk_stat_read: assert property ($past(rd && addr == A_STAT) |->
		rdata[1:0] == $past({osc_valid, osc_los}) && rdata[7:4] == $past(ref_valid)
		&& rdata[8] == $past(slew_active))
		else $error("status read differs from status outputs");
endmodule

// file: rqh_pkg.sv
package rqh_pkg;

	// Sizes of the block.
	localparam int NREF = 4;
	localparam int NLOOP = 3;
	localparam int PH_W = 24;

	// Clock rate and derived time bases.
	localparam int CLK_MHZ = 125;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
	localparam int OSC_WIN_NS = 1000;
	localparam int OSC_WIN_CYC = OSC_WIN_NS * CLK_MHZ / 1000;
	localparam int OSC_MIN_MHZ = 9;
	localparam int OSC_MAX_MHZ = 160;
	localparam int OSC_MIN_CNT = OSC_MIN_MHZ * OSC_WIN_NS / 1000;
	localparam int OSC_MAX_CNT = OSC_MAX_MHZ * OSC_WIN_NS / 1000;

	// Register byte addresses.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SLEW = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_BUILD = 8'h0C;
	localparam logic [7:0] A_LSTAT = 8'h10;
	localparam logic [7:0] A_REF_BASE = 8'h40;
	localparam logic [3:0] R_CFG = 4'h0;
	localparam logic [3:0] R_THR = 4'h4;
	localparam logic [3:0] R_FRQ = 4'h8;
	localparam logic [3:0] R_NOM = 4'hC;

	// Control bit positions.
	localparam int C_CANCEL = 0;
	localparam int C_SLEW = 1;
	localparam int C_BYP = 2;
	localparam int C_ZDS = 3;
	localparam int C_PPS = 4;

	// Monitor positions in the enable and flag nibbles.
	localparam int M_FREQ = 0;
	localparam int M_MISS = 1;
	localparam int M_RUNT = 2;
	localparam int M_PHV = 3;

	// Reset values.
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] SLEW_RST = 32'h0001_0001;
	localparam logic [31:0] REF_RST = 32'h0000_0000;

	// Per-reference monitor settings.
	typedef struct packed {
		logic [3:0] en;
		logic [1:0] avg;
		logic [15:0] vtime;
		logic [15:0] thr_ok;
		logic [15:0] thr_bad;
		logic [15:0] exp_cnt;
		logic [15:0] gate;
	} rqh_ref_cfg_t;

	// Per-reference monitor results.
	typedef struct packed {
		logic [3:0] flags;
		logic valid;
	} rqh_mon_t;

	typedef enum logic [1:0] {
		HS_TRACK = 2'b00,
		HS_SLEW = 2'b01,
		HS_HOLD = 2'b10
	} rqh_hs_t;

endpackage

// file: rqh_ref_mon.sv
module rqh_ref_mon (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ref_rise,
	input wire logic osc_rise,
	input wire logic tick,
	input wire rqh_pkg::rqh_ref_cfg_t cfg,
	input wire logic [3:0] ext_flags,
	output rqh_pkg::rqh_mon_t mon
);
	import rqh_pkg::*;

	logic [19:0] gate_cnt_reg;
	logic [23:0] ref_cnt_reg;
	logic fault_reg;
	logic [15:0] vcnt_reg;
	logic valid_reg;

	// Window length grows with averaging, so a verdict takes longer.
	wire [19:0] gate_end = 20'(cfg.gate) << cfg.avg;
	wire [19:0] gate_nxt = gate_cnt_reg + 20'd1;
	wire win_end = osc_rise && (gate_nxt >= gate_end);
	wire [23:0] exp_s = 24'(cfg.exp_cnt) << cfg.avg;
	wire [23:0] err = (ref_cnt_reg >= exp_s) ? ref_cnt_reg - exp_s : exp_s - ref_cnt_reg;
	wire fen = cfg.en[M_FREQ];
	// Disabled monitors are masked out and never disqualify.
	wire [3:0] flags = {ext_flags[3:1] & cfg.en[3:1], fault_reg & fen};
	wire any_flag = |flags;

	// Counts reference edges against oscillator edges; gaps only lower the average.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			gate_cnt_reg <= '0;
			ref_cnt_reg <= '0;
		end else if (!fen || win_end) begin
			gate_cnt_reg <= '0;
			ref_cnt_reg <= {23'd0, ref_rise};
		end else begin
			if (osc_rise)
				gate_cnt_reg <= gate_nxt;
			if (ref_rise && ref_cnt_reg != 24'hFF_FFFF)
				ref_cnt_reg <= ref_cnt_reg + 24'd1;
		end
	end

	// Hysteresis: clear below the valid limit, set above the invalid one.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			fault_reg <= 1'b0;
		else if (!fen)
			fault_reg <= 1'b0;
		else if (win_end && err < 24'(cfg.thr_ok))
			fault_reg <= 1'b0;
		else if (win_end && err > 24'(cfg.thr_bad))
			fault_reg <= 1'b1;
	end

	// Any flag drops validity at once and restarts the qualification time.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			vcnt_reg <= '0;
			valid_reg <= 1'b0;
		end else if (any_flag) begin
			vcnt_reg <= '0;
			valid_reg <= 1'b0;
		end else if (!valid_reg) begin
			if (vcnt_reg >= cfg.vtime)
				valid_reg <= 1'b1;
			else if (tick)
				vcnt_reg <= vcnt_reg + 16'd1;
		end
	end

	assign mon.flags = flags;
	assign mon.valid = valid_reg & ~any_flag;

endmodule

// file: rqh_src_model.sv
module rqh_src_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [4:0][7:0] half,
	output logic [3:0] ref_in,
	output logic osc_in
);
	logic [4:0][7:0] cnt_reg;
	logic [4:0] out_reg;

	// Sources toggle every half cycles; zero parks a source low like a dead input.
	// No edge is ever dropped, so a gap never exceeds one period.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			out_reg <= '0;
		end else begin
			for (int i = 0; i < 5; i++) begin
				cnt_reg[i] <= (cnt_reg[i] + 8'h01 >= half[i]) ? 8'h00 : cnt_reg[i] + 8'h01;
				out_reg[i] <= (half[i] == 8'h00) ? 1'b0 : out_reg[i] ^ (cnt_reg[i] + 8'h01 >= half[i]);
			end
		end
	end
	assign ref_in = out_reg[3:0];
	assign osc_in = out_reg[4];
endmodule

// file: rqh_top.sv
// Summary of operation
// - Cancellation absorbs fixed offset on locked switch; kept without slew until a switch or exit event that does not absorb.
// - References are frequency-locked if nominal or divided frequencies match.
// - Switching between unlocked references is treated as a locked switch; flock changes nothing.
// - Slew enabled: buildout shrinks by step limit once per interval.
// - Slew limits also apply on holdover or analog-only exit.
// - Both features off: full switch offset reaches loop, rate set by bandwidth.
// - One-pulse references switch hitlessly only with zero-delay sync off.
// - Gapped input yields average frequency; gaps kept within divided period.
// - Oscillator loss flag clears inside supported range, sets otherwise; the upper bound never trips, so only low counts set it.
// - Bypass makes oscillator always valid, leaves loss flag untouched.
// - Reference valid only after enabled monitors stay clear for set time.
// - Disabled monitor never flags and is ignored for qualification.
// - Enables, thresholds and timers are held separately per reference.
// - Pins show all enabled flags; status bits show selected inputs only.
// - Frequency error is measured against the oscillator input.
// - Fault flag clears below valid limit, sets above invalid, else holds.
// - Longer window or averaging delays the verdict, shrinks threshold range.
module rqh_top (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [rqh_pkg::NREF-1:0] ref_in,
	input wire logic osc_in,
	input wire logic [rqh_pkg::NREF-1:0][3:0] ext_flags,
	input wire logic [rqh_pkg::NLOOP-1:0][1:0] loop_sel,
	input wire logic switch_evt,
	input wire logic exit_evt,
	input wire logic signed [rqh_pkg::PH_W-1:0] phase_offset,
	input wire logic signed [rqh_pkg::PH_W-1:0] phase_err,
	output logic signed [rqh_pkg::PH_W-1:0] loop_phase_err,
	output logic [rqh_pkg::NREF-1:0] ref_valid,
	output logic [rqh_pkg::NREF-1:0] status_pins,
	output logic osc_valid,
	output logic osc_los,
	output logic slew_active
);
	import rqh_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register storage.

	logic [31:0] ctrl_reg;
	logic [31:0] slew_reg;
	logic [NREF-1:0][31:0] rcfg_reg;
	logic [NREF-1:0][31:0] rthr_reg;
	logic [NREF-1:0][31:0] rfrq_reg;
	logic [NREF-1:0][31:0] rnom_reg;
	logic [31:0] rdata_reg;

	// Address decode.
	wire in_ref = addr[7:6] == A_REF_BASE[7:6];
	wire [1:0] ridx = addr[5:4];
	wire [3:0] roff = addr[3:0];
	wire wr_ctrl = wr && addr == A_CTRL;
	wire wr_slew = wr && addr == A_SLEW;
	wire wr_cfg = wr && in_ref && roff == R_CFG;
	wire wr_thr = wr && in_ref && roff == R_THR;
	wire wr_frq = wr && in_ref && roff == R_FRQ;
	wire wr_nom = wr && in_ref && roff == R_NOM;

	// Control fields.
	wire cancel_en = ctrl_reg[C_CANCEL];
	wire phase_slew_enable = ctrl_reg[C_SLEW];
	wire osc_detector_bypass = ctrl_reg[C_BYP];
	wire zero_delay_sync = ctrl_reg[C_ZDS];
	wire pps_mode = ctrl_reg[C_PPS];
	wire [15:0] phase_slew_step_limit = slew_reg[15:0];
	wire [15:0] phase_slew_step_interval = slew_reg[31:16];

	// Global control writes.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RST;
			slew_reg <= SLEW_RST;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= wdata;
			if (wr_slew)
				slew_reg <= wdata;
		end
	end

	// Each reference keeps its own monitor settings.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rcfg_reg <= {NREF{REF_RST}};
			rthr_reg <= {NREF{REF_RST}};
			rfrq_reg <= {NREF{REF_RST}};
			rnom_reg <= {NREF{REF_RST}};
		end else begin
			if (wr_cfg)
				rcfg_reg[ridx] <= wdata;
			if (wr_thr)
				rthr_reg[ridx] <= wdata;
			if (wr_frq)
				rfrq_reg[ridx] <= wdata;
			if (wr_nom)
				rnom_reg[ridx] <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time base and input edges.

	logic [6:0] tick_cnt_reg;
	logic tick_reg;
	logic [NREF-1:0] ref_d_reg;
	logic osc_d_reg;

	wire [NREF-1:0] ref_rise = ref_in & ~ref_d_reg;
	wire osc_rise = osc_in & ~osc_d_reg;

	// One-cycle enable every microsecond.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == 7'(TICK_CYC - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 7'd1;
			tick_reg <= 1'b0;
		end
	end

	// Inputs are already synchronous; one stage gives the edges.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ref_d_reg <= '0;
			osc_d_reg <= 1'b0;
		end else begin
			ref_d_reg <= ref_in;
			osc_d_reg <= osc_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Coarse oscillator detector.
	// Sampling caps what can be seen at half the clock rate, so at most 63 edges fit
	// in a window and the upper bound of 160 can never trip.

	logic [6:0] owin_reg;
	logic [7:0] ocnt_reg;
	logic los_reg;

	wire owin_end = owin_reg == 7'(OSC_WIN_CYC - 1);
	wire osc_in_range = ocnt_reg >= 8'(OSC_MIN_CNT) && ocnt_reg <= 8'(OSC_MAX_CNT);

	// Counts oscillator edges over a fixed window and judges the range.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			owin_reg <= '0;
			ocnt_reg <= '0;
			los_reg <= 1'b1;
		end else if (owin_end) begin
			owin_reg <= '0;
			ocnt_reg <= {7'd0, osc_rise};
			los_reg <= ~osc_in_range;
		end else begin
			owin_reg <= owin_reg + 7'd1;
			if (osc_rise && ocnt_reg != 8'hFF)
				ocnt_reg <= ocnt_reg + 8'd1;
		end
	end

	assign osc_los = los_reg;
	assign osc_valid = osc_detector_bypass | ~los_reg;

	////////////////////////////////////////////////////////////////////////
	// Reference monitors.

	rqh_ref_cfg_t [NREF-1:0] cfg;
	rqh_mon_t [NREF-1:0] mon;

	genvar gi;
	generate
		for (gi = 0; gi < NREF; gi++) begin : g_ref
			assign cfg[gi].en = rcfg_reg[gi][3:0];
			assign cfg[gi].avg = rcfg_reg[gi][5:4];
			assign cfg[gi].vtime = rcfg_reg[gi][31:16];
			assign cfg[gi].thr_ok = rthr_reg[gi][15:0];
			assign cfg[gi].thr_bad = rthr_reg[gi][31:16];
			assign cfg[gi].exp_cnt = rfrq_reg[gi][15:0];
			assign cfg[gi].gate = rfrq_reg[gi][31:16];

			rqh_ref_mon u_mon (
				.clk_sys(clk_sys),
				.rstn(rstn),
				.ref_rise(ref_rise[gi]),
				.osc_rise(osc_rise),
				.tick(tick_reg),
				.cfg(cfg[gi]),
				.ext_flags(ext_flags[gi]),
				.mon(mon[gi])
			);

			assign ref_valid[gi] = mon[gi].valid;
			assign status_pins[gi] = |mon[gi].flags;
		end
	endgenerate

	// Readable flags follow each loop's selected input only.
	logic [11:0] loop_flags;
	always_comb begin
		loop_flags = '0;
		for (int l = 0; l < NLOOP; l++)
			loop_flags[4*l +: 4] = mon[loop_sel[l]].flags;
	end

	////////////////////////////////////////////////////////////////////////
	// Hitless switching for the first loop.

	rqh_hs_t hs_reg;
	rqh_hs_t hs_next;
	logic [1:0] prev_sel_reg;
	logic signed [PH_W-1:0] build_reg;
	logic signed [PH_W-1:0] build_next;
	logic [15:0] icnt_reg;
	logic signed [PH_W-1:0] lpe_reg;

	wire [1:0] new_sel = loop_sel[0];
	wire [15:0] nom_old = rnom_reg[prev_sel_reg][15:0];
	wire [15:0] nom_new = rnom_reg[new_sel][15:0];
	wire [15:0] div_old = rnom_reg[prev_sel_reg][31:16];
	wire [15:0] div_new = rnom_reg[new_sel][31:16];
	// Same nominal, or both divide down to one nonzero common rate.
	wire flock = nom_old == nom_new || (div_old == div_new && div_new != 16'h0000);
	// Zero-delay sync with one-pulse inputs forbids buildout.
	wire hit_ok = ~(pps_mode & zero_delay_sync);
	wire absorb = switch_evt && hit_ok && cancel_en;
	wire slew_go = (switch_evt || exit_evt) && phase_slew_enable && hit_ok;
	// A step falls on the tick that completes the interval, not the tick after it.
	wire [15:0] icnt_nxt = icnt_reg + 16'd1;
	wire step_tick = tick_reg && icnt_nxt >= phase_slew_step_interval;
	wire signed [PH_W-1:0] step_s = PH_W'(signed'({1'b0, phase_slew_step_limit}));
	wire signed [PH_W-1:0] build_abs = build_reg[PH_W-1] ? -build_reg : build_reg;
	wire signed [PH_W-1:0] build_add = build_reg + phase_offset;

	// Chooses how the offset at a switch or holdover exit is handled.
	always_comb begin
		hs_next = hs_reg;
		build_next = build_reg;
		if (slew_go) begin
			build_next = build_add;
			hs_next = HS_SLEW;
		end else if (absorb && flock) begin
			build_next = build_add;
			hs_next = HS_HOLD;
		end else if (absorb) begin
			build_next = build_add;
			hs_next = HS_HOLD;
		end else if (switch_evt || exit_evt) begin
			build_next = '0;
			hs_next = HS_TRACK;
		end else begin
			case (hs_reg)
				HS_SLEW: begin
					if (build_reg == '0) begin
						hs_next = HS_TRACK;
					end else if (step_tick) begin
						if (build_abs <= step_s)
							build_next = '0;
						else if (build_reg[PH_W-1])
							build_next = build_reg + step_s;
						else
							build_next = build_reg - step_s;
					end
				end
				HS_HOLD: hs_next = HS_HOLD;
				HS_TRACK: hs_next = HS_TRACK;
				default: hs_next = HS_TRACK;
			endcase
		end
	end

	// Interval counter restarts on each step and each new event.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			icnt_reg <= '0;
		else if (hs_reg != HS_SLEW || step_tick || slew_go)
			icnt_reg <= '0;
		else if (tick_reg)
			icnt_reg <= icnt_nxt;
	end

	// State, buildout and remembered selection.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hs_reg <= HS_TRACK;
			build_reg <= '0;
			prev_sel_reg <= 2'b00;
		end else begin
			hs_reg <= hs_next;
			build_reg <= build_next;
			if (switch_evt)
				prev_sel_reg <= new_sel;
		end
	end

	// The loop sees the raw error less the absorbed offset.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			lpe_reg <= '0;
		else
			lpe_reg <= phase_err - build_reg;
	end

	assign loop_phase_err = lpe_reg;
	assign slew_active = hs_reg == HS_SLEW;

	////////////////////////////////////////////////////////////////////////
	// Read path.

	wire [31:0] stat_word = {20'd0, hs_reg, 1'b0, slew_active, ref_valid,
		2'b00, osc_valid, osc_los};
	wire [31:0] build_word = 32'(build_reg);
	logic [31:0] rmux;

	// Read multiplexer; unmapped addresses read zero.
	always_comb begin
		rmux = '0;
		if (in_ref) begin
			case (roff)
				R_CFG: rmux = rcfg_reg[ridx];
				R_THR: rmux = rthr_reg[ridx];
				R_FRQ: rmux = rfrq_reg[ridx];
				R_NOM: rmux = rnom_reg[ridx];
				default: rmux = '0;
			endcase
		end else begin
			case (addr)
				A_CTRL: rmux = ctrl_reg;
				A_SLEW: rmux = slew_reg;
				A_STAT: rmux = stat_word;
				A_BUILD: rmux = build_word;
				A_LSTAT: rmux = {20'd0, loop_flags};
				default: rmux = '0;
			endcase
		end
	end

	// Data stands only in the cycle after the read strobe.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			rdata_reg <= '0;
		else
			rdata_reg <= rd ? rmux : 32'h0000_0000;
	end

	assign rdata = rdata_reg;

endmodule

// file: tb.sv
`define CHK(n, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("mismatch %s exp %0h got %0h", n, (e), (g)); \
	end \
end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rqh_pkg::*;
	logic clk_sys, rstn, wr, rd, switch_evt, exit_evt, osc_in, osc_valid, osc_los, slew_active;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [NREF-1:0] ref_in, ref_valid, status_pins;
	logic [NREF-1:0][3:0] ext_flags;
	logic [NLOOP-1:0][1:0] loop_sel;
	logic signed [PH_W-1:0] phase_offset, phase_err, loop_phase_err;
	logic [4:0][7:0] half;
	int errors, total_checks, n;
	logic [7:0] hv [4] = '{8'h04, 8'h02, 8'h03, 8'h04};
	logic fx [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	logic [31:0] cv [3] = '{32'h0000_0019, 32'h0000_0011, 32'h0000_0000};
	logic signed [PH_W-1:0] ov [3] = '{24'sh00_0032, 24'sh00_0028, 24'sh00_0046};
	logic signed [PH_W-1:0] bv [3] = '{24'sh00_0000, 24'sh00_0028, 24'sh00_0000};

	rqh_top dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ref_in(ref_in), .osc_in(osc_in), .ext_flags(ext_flags),
		.loop_sel(loop_sel), .switch_evt(switch_evt), .exit_evt(exit_evt),
		.phase_offset(phase_offset), .phase_err(phase_err), .loop_phase_err(loop_phase_err),
		.ref_valid(ref_valid), .status_pins(status_pins), .osc_valid(osc_valid),
		.osc_los(osc_los), .slew_active(slew_active));
	rqh_src_model src (.clk_sys(clk_sys), .rstn(rstn), .half(half), .ref_in(ref_in),
		.osc_in(osc_in));

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycles: strobes last one cycle and drop at the edge that takes them.
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string s);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		`CHK(s, e, rdata & m)
	endtask

	// One switch or exit pulse, then two edges so the buildout reaches the output.
	task automatic ev(input logic sw, input logic signed [PH_W-1:0] off);
		@(posedge clk_sys);
		switch_evt <= sw;
		exit_evt <= ~sw;
		phase_offset <= off;
		@(posedge clk_sys);
		switch_evt <= 1'b0;
		exit_evt <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	// Bounded wait on slew_active or ref_valid[0]; running out ends the run.
	task automatic count_until(input logic use_slew, input logic lvl, output int k);
		k = 0;
		while (((use_slew ? slew_active : ref_valid[0]) !== lvl) && k < 3000) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		if (k >= 3000) begin
			errors++;
			finish_test();
		end
	endtask

	task automatic finish_test();
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, wr, rd, switch_evt, exit_evt} = '0;
		{addr, wdata, ext_flags, phase_offset, half, errors, total_checks} = '0;
		loop_sel = {2'h2, 2'h1, 2'h0};
		phase_err = 24'sh00_03E8;
		half[0] = 8'h04;
		repeat (8) @(posedge clk_sys);
		#1;
		`CHK("rst_los", 1'b1, osc_los)
		@(posedge clk_sys);
		rstn <= 1'b1;
		rd_chk(A_CTRL, '1, CTRL_RST, "ctrl");
		rd_chk(A_SLEW, '1, SLEW_RST, "slew_rst");
		rd_chk(A_REF_BASE + 8'h14, '1, REF_RST, "thr1");
		wr_reg(8'h24, 32'hFFFF_FFFF);
		rd_chk(8'h24, '1, 32'h0000_0000, "unmapped");
		wr_reg(A_STAT, 32'hFFFF_FFFF);
		repeat (2 * OSC_WIN_CYC) @(posedge clk_sys);
		rd_chk(A_STAT, 32'h0000_0003, 32'h0000_0001, "los_dead");
		half[4] <= 8'h08;
		repeat (3 * OSC_WIN_CYC) @(posedge clk_sys);
		#1;
		`CHK("los_slow", 1'b1, osc_los)
		wr_reg(A_CTRL, 32'h0000_0004);
		#1;
		`CHK("byp_valid", 1'b1, osc_valid)
		`CHK("byp_los", 1'b1, osc_los)
		@(posedge clk_sys);
		half[4] <= 8'h06;
		repeat (3 * OSC_WIN_CYC) @(posedge clk_sys);
		#1;
		`CHK("los_ok", 1'b0, osc_los)
		// Oscillator is settled from here on.
		half[4] <= 8'h02;
		// Missing-pulse monitor on ref 0 only; ref 1 keeps all monitors off.
		wr_reg(A_REF_BASE, 32'h0003_0002);
		@(posedge clk_sys);
		ext_flags[0] <= 4'h2;
		ext_flags[1] <= 4'h4;
		#1;
		`CHK("pins", 4'h1, status_pins)
		`CHK("drop", 1'b0, ref_valid[0])
		`CHK("other", 1'b1, ref_valid[1])
		rd_chk(A_LSTAT, 32'h0000_0FFF, 32'h0000_0002, "lstat");
		@(posedge clk_sys);
		ext_flags <= '0;
		count_until(1'b0, 1'b1, n);
		`CHK("vtime", 1'b1, n >= 2 * TICK_CYC + 2 && n <= 3 * TICK_CYC + 1)
		// Frequency monitor: eight ref edges expected per window of sixteen osc edges.
		wr_reg(A_REF_BASE + 8'h04, 32'h0004_0002);
		wr_reg(A_REF_BASE + 8'h08, 32'h0010_0008);
		wr_reg(A_REF_BASE, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			half[0] <= hv[i];
			repeat (4 * TICK_CYC) @(posedge clk_sys);
			#1;
			`CHK("fdet", fx[i], status_pins[0])
			`CHK("fvalid", ~fx[i], ref_valid[0])
			rd_chk(A_LSTAT, 32'h0000_000F, {31'h0000_0000, fx[i]}, "lstat_f");
		end
		// Doubled averaging doubles the error, so an offset that held before now trips.
		wr_reg(A_REF_BASE, 32'h0000_0011);
		half[0] <= 8'h03;
		repeat (4 * TICK_CYC) @(posedge clk_sys);
		#1;
		`CHK("fdet_avg", 1'b1, status_pins[0])
		wr_reg(A_CTRL, 32'h0000_0001);
		ev(1'b1, 24'sh00_0064);
		`CHK("cancel_err", phase_err - 24'sh00_0064, loop_phase_err)
		rd_chk(A_STAT, 32'h0000_0D00, 32'h0000_0800, "hold");
		repeat (8 * TICK_CYC) @(posedge clk_sys);
		rd_chk(A_BUILD, '1, 32'h0000_0064, "build_keep");
		// One-pulse switch with zero-delay sync on (refused), then off (absorbed), then both features off.
		for (int i = 0; i < 3; i++) begin
			wr_reg(A_CTRL, cv[i]);
			ev(1'b1, ov[i]);
			`CHK("hit_err", phase_err - bv[i], loop_phase_err)
			rd_chk(A_BUILD, '1, 32'(bv[i]), "build_t");
		end
		wr_reg(A_SLEW, 32'h0001_000A);
		wr_reg(A_CTRL, 32'h0000_0002);
		ev(1'b0, 24'sh00_0023);
		`CHK("slewing", 1'b1, slew_active)
		count_until(1'b1, 1'b0, n);
		`CHK("slew_time", 1'b1, n >= 3 * TICK_CYC - 3 && n <= 4 * TICK_CYC + 2)
		rd_chk(A_BUILD, '1, 32'h0000_0000, "slew_end");
		ev(1'b1, 24'shFF_FFEC);
		`CHK("slew_sw", 1'b1, slew_active)
		count_until(1'b1, 1'b0, n);
		`CHK("slew_sw_t", 1'b1, n >= TICK_CYC - 3 && n <= 2 * TICK_CYC + 2)
		finish_test();
	end
endmodule

bind rqh_top rqh_checker chk (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .ext_flags(ext_flags), .switch_evt(switch_evt),
	.exit_evt(exit_evt), .phase_err(phase_err), .loop_phase_err(loop_phase_err),
	.ref_valid(ref_valid), .status_pins(status_pins), .osc_valid(osc_valid),
	.osc_los(osc_los), .slew_active(slew_active));
